// ===== src/multi_port_pin_config.sv
`timescale 1ns/100ps
// Function
// - config and data bits select pin set-up
// - each port has config, data, pin registers
// - analog port has six bonded bits only
// - analog-selected bits read back as zero
// - input-only pin never drives, always hi-z
// - watchdog option turns shared pin into fault
// - oscillator pin drives clock output outside reset
// - control data upper two bits read zero
// - data bit 7 write enters halt
// - data bit 6 write enters idle
// - config bit 6 selects alternate shift phase
// - control bits 0 to 5 individually configurable
// - all wake-up port pins report wake events
module multi_port_pin_config
  import gpio_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_reset,
  input  wire logic                  i_write,
  input  wire logic [ADDR_WIDTH-1:0] i_address,
  input  wire logic [PORT_WIDTH-1:0] i_write_data,
  input  wire logic [PORT_WIDTH-1:0] i_analog_select,
  input  wire logic                  i_watchdog_option,
  input  wire logic                  i_watchdog_fault,
  input  wire logic                  i_oscillator_clock,
  input  wire logic [PORT_WIDTH-1:0] i_b_pin,
  input  wire logic [PORT_WIDTH-1:0] i_g_pin,
  input  wire logic [PORT_WIDTH-1:0] i_l_pin,
  output logic      [PORT_WIDTH-1:0] o_read_data,
  output logic      [PORT_WIDTH-1:0] o_b_out,
  output logic      [PORT_WIDTH-1:0] o_b_oe,
  output logic      [PORT_WIDTH-1:0] o_b_pullup,
  output logic      [PORT_WIDTH-1:0] o_g_out,
  output logic      [PORT_WIDTH-1:0] o_g_oe,
  output logic      [PORT_WIDTH-1:0] o_g_pullup,
  output logic      [PORT_WIDTH-1:0] o_l_out,
  output logic      [PORT_WIDTH-1:0] o_l_oe,
  output logic      [PORT_WIDTH-1:0] o_l_pullup,
  output logic                       o_halt_request,
  output logic                       o_idle_request,
  output logic                       o_alternate_shift_phase,
  output logic      [PORT_WIDTH-1:0] o_wakeup_event
);

  // ==========================================================
  // pin set-up decode, shared by all three ports
  // returns {output enable, output level, pull-up enable}
  function automatic logic [2:0] pin_setup(input logic cfg,
                                           input logic data);
    logic [2:0] result;
    result = {cfg, data, ~cfg & data};
    return result;
  endfunction : pin_setup

  // ==========================================================
  // registers
  logic [PORT_WIDTH-1:0] b_data;
  logic [PORT_WIDTH-1:0] b_config;
  logic [PORT_WIDTH-1:0] g_data;
  logic [PORT_WIDTH-1:0] g_config;
  logic [PORT_WIDTH-1:0] l_data;
  logic [PORT_WIDTH-1:0] l_config;
  logic [PORT_WIDTH-1:0] b_level;
  logic [PORT_WIDTH-1:0] g_level;
  logic [PORT_WIDTH-1:0] l_level;
  logic [PORT_WIDTH-1:0] l_level_last;
  logic [PIN_COUNT-1:0]  raw_pins;
  logic [PIN_COUNT-1:0]  sync_pins;
  logic [PORT_WIDTH-1:0] next_read_data;
  logic [PORT_WIDTH-1:0] next_b_out;
  logic [PORT_WIDTH-1:0] next_b_oe;
  logic [PORT_WIDTH-1:0] next_b_pullup;
  logic [PORT_WIDTH-1:0] next_g_out;
  logic [PORT_WIDTH-1:0] next_g_oe;
  logic [PORT_WIDTH-1:0] next_g_pullup;
  logic [PORT_WIDTH-1:0] next_l_out;
  logic [PORT_WIDTH-1:0] next_l_oe;
  logic [PORT_WIDTH-1:0] next_l_pullup;

  // ==========================================================
  // pin input sampling
  assign raw_pins = {i_l_pin, i_g_pin, i_b_pin};
  assign b_level  = sync_pins[PORT_WIDTH-1:0];
  assign g_level  = sync_pins[2*PORT_WIDTH-1:PORT_WIDTH];
  assign l_level  = sync_pins[PIN_COUNT-1:2*PORT_WIDTH];

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
    pin_input_sync u_sync (
      .i_clock (i_clock),
      .i_reset (i_reset),
      .i_pin   (raw_pins[i]),
      .o_level (sync_pins[i])
    );
  end

  // ==========================================================
  // register writes
  // reset clears all
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      b_data   <= RESET_VALUE;
      b_config <= RESET_VALUE;
      g_data   <= RESET_VALUE;
      g_config <= RESET_VALUE;
      l_data   <= RESET_VALUE;
      l_config <= RESET_VALUE;
    end else if (i_write) begin
      case (i_address)
        ADDR_B_DATA:   b_data   <= i_write_data & B_BONDED_MASK;
        ADDR_B_CONFIG: b_config <= i_write_data & B_BONDED_MASK;
        ADDR_G_DATA:   g_data   <= i_write_data & G_DATA_READ_MASK;
        ADDR_G_CONFIG: g_config <= i_write_data;
        ADDR_L_DATA:   l_data   <= i_write_data;
        ADDR_L_CONFIG: l_config <= i_write_data;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // power mode strobes and serial clock phase
  // halt and idle bits are commands, not stored state
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_halt_request <= 1'b0;
      o_idle_request <= 1'b0;
    end else begin
      o_halt_request <= i_write && (i_address == ADDR_G_DATA)
                        && i_write_data[G_HALT_BIT];
      o_idle_request <= i_write && (i_address == ADDR_G_DATA)
                        && i_write_data[G_IDLE_BIT];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_alternate_shift_phase <= 1'b0;
    end else begin
      o_alternate_shift_phase <= g_config[G_ALT_PHASE_BIT];
    end
  end

  // ==========================================================
  // pad drive decode
  always_comb begin
    for (int i = 0; i < PORT_WIDTH; i++) begin
      {next_b_oe[i], next_b_out[i], next_b_pullup[i]} =
        pin_setup(b_config[i], b_data[i]);
      {next_g_oe[i], next_g_out[i], next_g_pullup[i]} =
        pin_setup(g_config[i], g_data[i]);
      {next_l_oe[i], next_l_out[i], next_l_pullup[i]} =
        pin_setup(l_config[i], l_data[i]);
    end
    next_b_oe     = next_b_oe & B_BONDED_MASK;
    next_b_pullup = next_b_pullup & B_BONDED_MASK;
    // fault pin: pulls low on fault, weak pull-up else
    if (i_watchdog_option) begin
      next_g_oe[G_WATCHDOG_BIT]     = i_watchdog_fault;
      next_g_out[G_WATCHDOG_BIT]    = 1'b0;
      next_g_pullup[G_WATCHDOG_BIT] = 1'b1;
    end
    next_g_oe[G_INPUT_ONLY_BIT]     = 1'b0;
    next_g_out[G_INPUT_ONLY_BIT]    = 1'b0;
    next_g_pullup[G_INPUT_ONLY_BIT] = 1'b0;
    next_g_oe[G_OSC_BIT]            = 1'b1;
    next_g_out[G_OSC_BIT]           = i_oscillator_clock;
    next_g_pullup[G_OSC_BIT]        = 1'b0;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_b_out    <= RESET_VALUE;
      o_b_oe     <= RESET_VALUE;
      o_b_pullup <= RESET_VALUE;
      o_g_out    <= RESET_VALUE;
      o_g_oe     <= RESET_VALUE;
      o_g_pullup <= RESET_VALUE;
      o_l_out    <= RESET_VALUE;
      o_l_oe     <= RESET_VALUE;
      o_l_pullup <= RESET_VALUE;
    end else begin
      o_b_out    <= next_b_out;
      o_b_oe     <= next_b_oe;
      o_b_pullup <= next_b_pullup;
      o_g_out    <= next_g_out;
      o_g_oe     <= next_g_oe;
      o_g_pullup <= next_g_pullup;
      o_l_out    <= next_l_out;
      o_l_oe     <= next_l_oe;
      o_l_pullup <= next_l_pullup;
    end
  end

  // ==========================================================
  // read-back
  always_comb begin
    case (i_address)
      ADDR_B_DATA:   next_read_data = b_data;
      ADDR_B_CONFIG: next_read_data = b_config;
      // masked pin bits read as zero
      ADDR_B_PIN:    next_read_data = b_level & B_BONDED_MASK
                                      & ~i_analog_select;
      ADDR_G_DATA:   next_read_data = g_data & G_DATA_READ_MASK;
      ADDR_G_CONFIG: next_read_data = g_config;
      ADDR_G_PIN:    next_read_data = g_level;
      ADDR_L_DATA:   next_read_data = l_data;
      ADDR_L_CONFIG: next_read_data = l_config;
      ADDR_L_PIN:    next_read_data = l_level;
      default:       next_read_data = RESET_VALUE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_read_data <= RESET_VALUE;
    end else begin
      o_read_data <= next_read_data;
    end
  end

  // ==========================================================
  // wake-up edges
  // any level change wakes
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      l_level_last   <= RESET_VALUE;
      o_wakeup_event <= RESET_VALUE;
    end else begin
      l_level_last   <= l_level;
      o_wakeup_event <= l_level ^ l_level_last;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_halt_write;
    i_write && i_address == ADDR_G_DATA && i_write_data[G_HALT_BIT];
  endsequence

  // a back-to-back halt write may legally hold the strobe high
  sequence s_halt_pulse;
    o_halt_request ##1
      o_halt_request == $past(i_write && i_address == ADDR_G_DATA
                              && i_write_data[G_HALT_BIT]);
  endsequence

  a_push_pull_drive: assert property (
    l_config[0] |=> o_l_oe[0] && o_l_out[0] == $past(l_data[0]))
    else $error("push-pull pin not driving data");

  a_weak_pullup: assert property (
    !l_config[2] && l_data[2] |=> !o_l_oe[2] && o_l_pullup[2])
    else $error("pull-up input set-up wrong");

  a_pin_readback: assert property (
    i_address == ADDR_L_PIN |=> o_read_data == $past(l_level))
    else $error("pin register read mismatch");

  a_unbonded_zero: assert property (
    i_address == ADDR_B_PIN |=> (o_read_data & ~B_BONDED_MASK) == 8'h00)
    else $error("unbonded bits not masked");

  a_analog_masked: assert property (
    i_address == ADDR_B_PIN
    |=> (o_read_data & $past(i_analog_select)) == 8'h00)
    else $error("analog bit read as digital");

  a_input_only: assert property (
    !o_g_oe[G_INPUT_ONLY_BIT] && !o_g_pullup[G_INPUT_ONLY_BIT])
    else $error("input-only pin driven");

  a_watchdog_pin: assert property (
    i_watchdog_option |=> o_g_pullup[G_WATCHDOG_BIT]
    && o_g_oe[G_WATCHDOG_BIT] == $past(i_watchdog_fault))
    else $error("watchdog pin set-up wrong");

  a_osc_output: assert property (
    !$past(i_reset) |-> o_g_oe[G_OSC_BIT]
    && o_g_out[G_OSC_BIT] == $past(i_oscillator_clock))
    else $error("oscillator pin not clock output");

  a_g_upper_zero: assert property (
    i_address == ADDR_G_DATA |=> o_read_data[7:6] == 2'b00)
    else $error("control data upper bits nonzero");

  a_halt_request: assert property (
    s_halt_write |=> s_halt_pulse)
    else $error("halt request not a single pulse");

  a_idle_request: assert property (
    o_idle_request |-> $past(i_write && i_address == ADDR_G_DATA
                             && i_write_data[G_IDLE_BIT]))
    else $error("idle request without cause");

  a_alt_phase: assert property (
    i_write && i_address == ADDR_G_CONFIG
    |=> ##1 o_alternate_shift_phase == $past(i_write_data[G_ALT_PHASE_BIT], 2))
    else $error("alternate phase not following config");

  a_g_bit_config: assert property (
    g_config[3] |=> o_g_oe[3])
    else $error("control bit not configurable");

  a_wakeup_event: assert property (
    l_level[5] != $past(l_level[5]) |=> o_wakeup_event[5])
    else $error("wake-up edge missed");

  a_reset_clear: assert property (
    $past(i_reset) |-> g_config == 8'h00 && l_data == 8'h00
    && o_b_oe == 8'h00)
    else $error("registers not cleared by reset");

endmodule : multi_port_pin_config

// ===== include/gpio_pkg.sv
// ==========================================================
// port register map and pin layout
package gpio_pkg;
  localparam int         PORT_WIDTH       = 8;
  localparam int         ADDR_WIDTH       = 4;
  localparam int         PIN_COUNT        = 3 * PORT_WIDTH;

  // ==========================================================
  // register select codes
  localparam logic [3:0] ADDR_B_DATA      = 4'h0;
  localparam logic [3:0] ADDR_B_CONFIG    = 4'h1;
  localparam logic [3:0] ADDR_B_PIN       = 4'h2;
  localparam logic [3:0] ADDR_G_DATA      = 4'h4;
  localparam logic [3:0] ADDR_G_CONFIG    = 4'h5;
  localparam logic [3:0] ADDR_G_PIN       = 4'h6;
  localparam logic [3:0] ADDR_L_DATA      = 4'h8;
  localparam logic [3:0] ADDR_L_CONFIG    = 4'h9;
  localparam logic [3:0] ADDR_L_PIN       = 4'ha;

  // ==========================================================
  // values after reset and bit masks
  localparam logic [7:0] RESET_VALUE      = 8'h00;
  localparam logic [7:0] B_BONDED_MASK    = 8'hfc;
  localparam logic [7:0] G_DATA_READ_MASK = 8'h3f;

  // ==========================================================
  // control port bit positions
  localparam int         G_WATCHDOG_BIT   = 1;
  localparam int         G_INPUT_ONLY_BIT = 6;
  localparam int         G_OSC_BIT        = 7;
  localparam int         G_IDLE_BIT       = 6;
  localparam int         G_HALT_BIT       = 7;
  localparam int         G_ALT_PHASE_BIT  = 6;
endpackage : gpio_pkg

// ===== src/pin_input_sync.sv
`timescale 1ns/100ps
// ==========================================================
// three-stage pin synchroniser with agreement filter
module pin_input_sync (
  input  wire logic i_clock,
  input  wire logic i_reset,
  input  wire logic i_pin,
  output logic      o_level
);
  logic stage1;
  logic stage2;
  logic stage3;

  // stage1 feeds only stage2 to keep metastability contained
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts only once two settled stages agree
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_level <= 1'b0;
    end else if (stage2 == stage3) begin
      o_level <= stage3;
    end
  end
endmodule : pin_input_sync

// ===== verification/board_model.sv
`timescale 1ns/100ps
// ==========================================================
// board side of one port: keys, leds and open pads
module board_model (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pullup,
  input  wire logic [7:0] i_key_enable,
  input  wire logic [7:0] i_key_level,
  output logic      [7:0] o_pad
);
  logic [7:0] float_level = 8'h00;

  // an undriven pad never holds a clean level, so keep it moving
  always @(posedge i_clock) begin
    float_level <= ~float_level;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (i_oe[i]) begin
        o_pad[i] = i_out[i];
      end else if (i_key_enable[i]) begin
        o_pad[i] = i_key_level[i];
      end else if (i_pullup[i]) begin
        o_pad[i] = 1'b1;
      end else begin
        o_pad[i] = float_level[i];
      end
    end
  end
endmodule : board_model

// ===== verification/tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// self-checking bench for the three configurable ports
module tb_top
  import gpio_pkg::*;
;
  logic       i_clock = 1'b0;
  logic       i_reset = 1'b1;
  logic       i_write = 1'b0;
  logic [3:0] i_address = 4'h0;
  logic [7:0] i_write_data = 8'h00;
  logic [7:0] i_analog_select = 8'h00;
  logic       i_watchdog_option = 1'b0;
  logic       i_watchdog_fault = 1'b0;
  logic       i_oscillator_clock = 1'b0;
  logic [7:0] b_pad, g_pad, l_pad, read_data, b_out, b_oe, b_pullup;
  logic [7:0] g_out, g_oe, g_pullup, l_out, l_oe, l_pullup, wakeup;
  logic       halt, idle, phase;
  logic [7:0] key_en [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] key_val [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] wake_count [8] = '{default: 8'h00};
  logic [7:0] snap [8];
  logic [7:0] d;
  logic [3:0] regs [6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9};
  int         n_fail = 0;
  int         total_checks = 0;

  always #25 i_clock = ~i_clock;

  multi_port_pin_config dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_write(i_write),
    .i_address(i_address), .i_write_data(i_write_data),
    .i_analog_select(i_analog_select),
    .i_watchdog_option(i_watchdog_option),
    .i_watchdog_fault(i_watchdog_fault),
    .i_oscillator_clock(i_oscillator_clock),
    .i_b_pin(b_pad), .i_g_pin(g_pad), .i_l_pin(l_pad),
    .o_read_data(read_data), .o_b_out(b_out), .o_b_oe(b_oe),
    .o_b_pullup(b_pullup), .o_g_out(g_out), .o_g_oe(g_oe),
    .o_g_pullup(g_pullup), .o_l_out(l_out), .o_l_oe(l_oe),
    .o_l_pullup(l_pullup), .o_halt_request(halt), .o_idle_request(idle),
    .o_alternate_shift_phase(phase), .o_wakeup_event(wakeup));

  board_model b_board (.i_clock(i_clock), .i_out(b_out), .i_oe(b_oe),
    .i_pullup(b_pullup), .i_key_enable(key_en[0]),
    .i_key_level(key_val[0]), .o_pad(b_pad));
  board_model g_board (.i_clock(i_clock), .i_out(g_out), .i_oe(g_oe),
    .i_pullup(g_pullup), .i_key_enable(key_en[1]),
    .i_key_level(key_val[1]), .o_pad(g_pad));
  board_model l_board (.i_clock(i_clock), .i_out(l_out), .i_oe(l_oe),
    .i_pullup(l_pullup), .i_key_enable(key_en[2]),
    .i_key_level(key_val[2]), .o_pad(l_pad));

  always @(posedge i_clock) begin
    for (int i = 0; i < 8; i++) begin
      if (wakeup[i] === 1'b1) begin
        wake_count[i] <= wake_count[i] + 8'h01;
      end
    end
  end

  // ==========================================================
  // access tasks
  task automatic settle(input int n);
    repeat (n) @(negedge i_clock);
  endtask : settle

  task automatic write_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_write      <= 1'b1;
    i_address    <= a;
    i_write_data <= v;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clock);
    i_address <= a;
    @(posedge i_clock);
    @(negedge i_clock);
    v = read_data;
  endtask : read_reg

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] expected);
    total_checks++;
    if (seen !== expected) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, expected, seen);
    end
  endtask : check

  // strobe stands for the one cycle after the edge taking the write
  task automatic power(input logic [7:0] v);
    write_reg(ADDR_G_DATA, v);
    settle(1);
    check("power", {6'h00, halt, idle}, {6'h00, v[7:6]});
    settle(1);
    check("power_end", {6'h00, halt, idle}, 8'h00);
  endtask : power

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // watchdog, well beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge i_clock);
    n_fail++;
    complete_run();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge i_clock);
    i_reset <= 1'b0;
    settle(2);
    for (int i = 0; i < 6; i++) begin
      read_reg(regs[i], d);
      check("reset_reg", d, RESET_VALUE);
    end
    check("reset_oe", l_oe | b_oe | g_oe[6:0], 8'h00);
    check("osc_oe", {7'h00, g_oe[7]}, 8'h01);
    $display("test reset done");

    write_reg(ADDR_L_DATA, 8'h55);
    write_reg(ADDR_L_CONFIG, 8'h0f);
    @(posedge i_clock);
    key_en[2]  <= 8'hb0;
    key_val[2] <= 8'h20;
    settle(8);
    check("l_oe", l_oe, 8'h0f);
    check("l_out", l_out & 8'h0f, 8'h05);
    check("l_pullup", l_pullup, 8'h50);
    read_reg(ADDR_L_PIN, d);
    check("l_pin", d, 8'h65);
    read_reg(ADDR_L_DATA, d);
    check("l_data", d, 8'h55);
    read_reg(ADDR_L_CONFIG, d);
    check("l_config", d, 8'h0f);
    $display("test l_port done");

    @(posedge i_clock);
    i_analog_select <= 8'h0c;
    write_reg(ADDR_B_DATA, 8'h5f);
    write_reg(ADDR_B_CONFIG, 8'hf0);
    settle(8);
    check("b_oe", b_oe, 8'hf0);
    check("b_out", b_out & 8'hf0, 8'h50);
    check("b_pullup", b_pullup & B_BONDED_MASK, 8'h0c);
    read_reg(ADDR_B_PIN, d);
    check("b_pin", d, 8'h50);
    write_reg(4'hf, 8'hff);
    read_reg(4'hf, d);
    check("unmapped", d, 8'h00);
    read_reg(ADDR_B_DATA, d);
    check("b_data", d & B_BONDED_MASK, 8'h5c);
    write_reg(ADDR_B_CONFIG, 8'hff);
    settle(3);
    check("b_unbonded", b_oe, 8'hfc);
    $display("test b_port done");

    write_reg(ADDR_G_CONFIG, 8'h7f);
    write_reg(ADDR_G_DATA, 8'h17);
    settle(3);
    check("g_oe", g_oe, 8'hbf);
    check("g_out", g_out & 8'h3f, 8'h17);
    check("phase_on", {7'h00, phase}, 8'h01);
    power(8'h80);
    power(8'h40);
    power(8'hd7);
    read_reg(ADDR_G_DATA, d);
    check("g_data", d, 8'h17);
    @(posedge i_clock);
    i_watchdog_option <= 1'b1;
    i_watchdog_fault  <= 1'b1;
    settle(3);
    check("wd_fault", {5'h00, g_oe[1], g_out[1], g_pullup[1]}, 8'h05);
    @(posedge i_clock);
    i_watchdog_fault <= 1'b0;
    settle(3);
    check("wd_idle", {5'h00, g_oe[1], g_out[1], g_pullup[1]}, 8'h01);
    @(posedge i_clock);
    i_watchdog_option <= 1'b0;
    settle(3);
    check("wd_off", {5'h00, g_oe[1], g_out[1], g_pullup[1]}, 8'h06);
    @(posedge i_clock);
    i_oscillator_clock <= 1'b1;
    settle(5);
    check("osc_high", {7'h00, g_out[7]}, 8'h01);
    @(posedge i_clock);
    i_oscillator_clock <= 1'b0;
    settle(5);
    check("osc_low", {7'h00, g_out[7]}, 8'h00);
    write_reg(ADDR_G_CONFIG, 8'h3f);
    settle(3);
    check("phase_off", {7'h00, phase}, 8'h00);
    $display("test g_port done");

    write_reg(ADDR_L_CONFIG, 8'h00);
    @(posedge i_clock);
    key_en[2]  <= 8'hff;
    key_val[2] <= 8'h00;
    settle(10);
    snap = wake_count;
    @(posedge i_clock);
    key_val[2] <= 8'hff;
    settle(10);
    for (int i = 0; i < 8; i++) begin
      check("wake", wake_count[i] - snap[i], 8'h01);
    end
    $display("test wakeup done");
    complete_run();
  end
endmodule : tb_top
